// ### i2c_hold_pkg.sv
// Purpose: constants and carriers for the target-side hold and collision control
// Assumes: one system clock at 250 MHz, synchronous active-low reset
// Notes: nothing here is imported; every use is package-qualified
// Notes on behaviour
// R01 - Address hold on: after eighth falling clock of matching address, clear release, drive clock low
// R02 - Address hold off: no clock stretch after a matching address byte
// R03 - Data hold on: after eighth falling clock of data byte, clear release, hold clock low; code holds only a received byte (tx_drive_i low)
// R04 - Data hold off: no clock stretch after a received data byte
// R05 - Collision detect off: no bus collision events raised as target
// R06 - Driving data high but sampling low on rising clock: set collision flag, go idle
// R07 - Collision detect on: target-mode collisions raise the collision flag
// R08 - Daisy-chain four-wire mode: software may ignore earlier bytes; overflow flag still set
// R09 - Held clock stays low until software sets the release bit again
`default_nettype none
package i2c_hold_pkg;
    localparam logic [3:0] bits_per_byte = 4'h8;
    localparam logic [6:0] own_addr_reset = 7'h00;

    typedef enum logic [1:0] {
        st_idle,
        st_addr,
        st_data
    } phase_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_s;
endpackage
`default_nettype wire

// ### sync2.sv
// Purpose: two-flop synchroniser for one pin bit
// Assumes: input is asynchronous to clk_i
// Notes: the first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic meta;
        logic q;
    } st_s;
    st_s r;
    st_s next_r;
    always_comb begin
        next_r.meta = d_i;
        next_r.q = r.meta;
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r <= '{meta: 1'b1, q: 1'b1};
        end else begin
            r <= next_r;
        end
    end
    assign q_o = r.q;
endmodule
`default_nettype wire

// ### i2c_slave_hold_collision_ctrl.sv
// Purpose: target-side clock stretch after address/data byte and bus collision detect
// Assumes: external controller drives the serial clock; pins sampled by clk_i
// Notes: release bit is set by software via a pulse; hardware clears it on hold
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_hold_collision_ctrl (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_hold_enable_i,
    input wire logic data_hold_enable_i,
    input wire logic target_collision_detect_enable_i,
    input wire logic [6:0] own_addr_i,
    input wire logic release_set_i,
    input wire logic tx_drive_i,
    input wire logic tx_bit_i,
    input wire logic collision_flag_clear_i,
    input wire logic spi_byte_done_i,
    input wire logic rx_buffer_full_i,
    input wire logic overflow_flag_clear_i,
    output logic clock_release_bit_o,
    output logic bus_collision_flag_o,
    output logic receive_overflow_flag_o,
    output logic addr_match_o,
    output logic [7:0] rx_byte_o,
    output logic byte_done_o
);
    typedef struct packed {
        i2c_hold_pkg::bus_pins_s prev;
        i2c_hold_pkg::phase_e phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] rx_byte;
        logic release_bit;
        logic collision;
        logic overflow;
        logic match;
        logic done;
        logic drive_low_sda;
        logic ack_pending;
    } st_s;

    st_s r;
    st_s next_r;
    i2c_hold_pkg::bus_pins_s pin;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic driving_high;
    logic bit_rise;
    logic byte_fall;
    logic ack_fall;
    logic addr_hit;

    sync2 u_sync_scl (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(scl_i),
        .q_o(pin.scl)
    );
    sync2 u_sync_sda (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(sda_i),
        .q_o(pin.sda)
    );

    assign scl_rise = pin.scl && !r.prev.scl;
    assign scl_fall = !pin.scl && r.prev.scl;
    assign start_seen = r.prev.sda && !pin.sda && pin.scl && r.prev.scl;
    assign stop_seen = !r.prev.sda && pin.sda && pin.scl && r.prev.scl;
    assign driving_high = tx_drive_i && tx_bit_i && (r.phase == i2c_hold_pkg::st_data);
    // the count moves on rises, so the clock fall right after a start is no bit
    assign bit_rise = scl_rise && (r.bit_cnt < i2c_hold_pkg::bits_per_byte);
    assign byte_fall = scl_fall && (r.bit_cnt == i2c_hold_pkg::bits_per_byte);
    assign ack_fall = scl_fall && (r.bit_cnt == i2c_hold_pkg::bits_per_byte + 4'h1);
    assign addr_hit = (r.shift[7:1] == own_addr_i);

    always_comb begin
        next_r = r;
        next_r.prev = pin;
        next_r.done = 1'b0;
        if (release_set_i) begin
            next_r.release_bit = 1'b1; // R09
        end
        if (collision_flag_clear_i) begin
            next_r.collision = 1'b0;
        end
        if (overflow_flag_clear_i) begin
            next_r.overflow = 1'b0;
        end
        // overflow rises even when software ignores chained bytes
        if (spi_byte_done_i && rx_buffer_full_i) begin
            next_r.overflow = 1'b1; // R08
        end
        if (scl_fall && r.ack_pending) begin
            next_r.ack_pending = 1'b0;
            next_r.drive_low_sda = 1'b0;
        end
        case (r.phase)
            i2c_hold_pkg::st_idle: begin
                next_r.bit_cnt = 4'h0;
                next_r.drive_low_sda = 1'b0;
            end
            i2c_hold_pkg::st_addr, i2c_hold_pkg::st_data: begin
                // eight data rises and the ack rise
                if (scl_rise && r.bit_cnt <= i2c_hold_pkg::bits_per_byte) begin
                    next_r.bit_cnt = r.bit_cnt + 4'h1;
                end
                if (bit_rise) begin
                    next_r.shift = {r.shift[6:0], pin.sda};
                    // data line low while we drive high: lost the bus
                    if (driving_high && !pin.sda) begin
                        if (target_collision_detect_enable_i) begin
                            next_r.collision = 1'b1; // R06 R07
                        end
                        // R05: with detect off no flag is raised
                        next_r.phase = i2c_hold_pkg::st_idle; // R06
                        next_r.drive_low_sda = 1'b0;
                        next_r.ack_pending = 1'b0;
                    end
                end
                // eighth fall: byte complete
                if (byte_fall) begin
                    next_r.rx_byte = r.shift;
                    next_r.done = 1'b1;
                    if (r.phase == i2c_hold_pkg::st_addr) begin
                        if (addr_hit) begin
                            next_r.match = 1'b1;
                            next_r.drive_low_sda = 1'b1;
                            next_r.ack_pending = 1'b1;
                            if (address_hold_enable_i) begin
                                next_r.release_bit = 1'b0; // R01
                            end
                            // R02: hold off leaves release untouched
                        end else begin
                            next_r.match = 1'b0;
                            next_r.phase = i2c_hold_pkg::st_idle;
                        end
                    end else if (!tx_drive_i) begin
                        next_r.drive_low_sda = 1'b1;
                        next_r.ack_pending = 1'b1;
                        if (data_hold_enable_i) begin
                            next_r.release_bit = 1'b0; // R03
                        end
                        // R04: hold off leaves release untouched
                    end
                end
                // ninth clock done: next byte
                if (ack_fall) begin
                    next_r.bit_cnt = 4'h0;
                    if (r.phase == i2c_hold_pkg::st_addr) begin
                        next_r.phase = i2c_hold_pkg::st_data;
                    end
                end
            end
            default: begin
                next_r.phase = i2c_hold_pkg::st_idle;
            end
        endcase
        if (start_seen) begin
            next_r.phase = i2c_hold_pkg::st_addr;
            next_r.bit_cnt = 4'h0;
            next_r.match = 1'b0;
            next_r.drive_low_sda = 1'b0;
            next_r.ack_pending = 1'b0;
        end else if (stop_seen) begin
            next_r.phase = i2c_hold_pkg::st_idle;
            next_r.match = 1'b0;
            next_r.drive_low_sda = 1'b0;
            next_r.ack_pending = 1'b0;
        end
    end

    // pin history starts at the idle-high level so reset gives no false edge

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r <= '{prev: '{scl: 1'b1, sda: 1'b1},
                   phase: i2c_hold_pkg::st_idle,
                   bit_cnt: 4'h0,
                   shift: 8'h00,
                   rx_byte: 8'h00,
                   release_bit: 1'b1,
                   collision: 1'b0,
                   overflow: 1'b0,
                   match: 1'b0,
                   done: 1'b0,
                   drive_low_sda: 1'b0,
                   ack_pending: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // clock held low while release bit is clear
    assign scl_o = 1'b0;
    assign scl_oe_o = !r.release_bit; // R01 R03 R09
    assign sda_o = r.drive_low_sda ? 1'b0 : tx_bit_i;
    // pull for an ack or for a transmitted zero
    assign sda_oe_o = r.drive_low_sda || (tx_drive_i && !tx_bit_i &&
                      r.phase == i2c_hold_pkg::st_data);
    assign clock_release_bit_o = r.release_bit;
    assign bus_collision_flag_o = r.collision;
    assign receive_overflow_flag_o = r.overflow;
    assign addr_match_o = r.match;
    assign rx_byte_o = r.rx_byte;
    assign byte_done_o = r.done;
endmodule
`default_nettype wire

// ### i2c_hold_chk.sv
// Purpose: port checks of the hold block
// Assumes: one clock domain
// Notes: bound below the module
`timescale 1ns/1ps
`default_nettype none
module i2c_hold_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic address_hold_enable_i,
    input wire logic data_hold_enable_i,
    input wire logic target_collision_detect_enable_i,
    input wire logic release_set_i,
    input wire logic spi_byte_done_i,
    input wire logic rx_buffer_full_i,
    input wire logic scl_oe_o,
    input wire logic clock_release_bit_o,
    input wire logic bus_collision_flag_o,
    input wire logic receive_overflow_flag_o,
    input wire logic addr_match_o,
    input wire logic byte_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_pull_tie: assert property ($rose(scl_oe_o) |-> byte_done_o &&
        (address_hold_enable_i || data_hold_enable_i)) else $error("clock pull without hold");
    a_release_frees: assert property (release_set_i |=> clock_release_bit_o)
        else $error("release pulse ignored");
    a_hold_stays: assert property (!clock_release_bit_o && !release_set_i
        |=> !clock_release_bit_o) else $error("hold dropped early");
    a_fall_on_byte: assert property ($fell(clock_release_bit_o) |-> byte_done_o)
        else $error("hold without byte");
    a_no_hold_off: assert property (!address_hold_enable_i && !data_hold_enable_i
        && clock_release_bit_o |=> clock_release_bit_o) else $error("stretch while off");
    a_addr_hold: assert property ($rose(addr_match_o)
        |-> clock_release_bit_o == !address_hold_enable_i) else $error("address hold wrong");
    a_no_coll_flag: assert property (!target_collision_detect_enable_i
        && !bus_collision_flag_o |=> !bus_collision_flag_o) else $error("collision while off");
    a_ovf_set: assert property (spi_byte_done_i && rx_buffer_full_i
        |=> receive_overflow_flag_o) else $error("overflow not set");
endmodule
bind i2c_slave_hold_collision_ctrl i2c_hold_chk chk_u (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .address_hold_enable_i(address_hold_enable_i),
    .data_hold_enable_i(data_hold_enable_i),
    .target_collision_detect_enable_i(target_collision_detect_enable_i),
    .release_set_i(release_set_i),
    .spi_byte_done_i(spi_byte_done_i),
    .rx_buffer_full_i(rx_buffer_full_i),
    .scl_oe_o(scl_oe_o),
    .clock_release_bit_o(clock_release_bit_o),
    .bus_collision_flag_o(bus_collision_flag_o),
    .receive_overflow_flag_o(receive_overflow_flag_o),
    .addr_match_o(addr_match_o),
    .byte_done_o(byte_done_o)
);
`default_nettype wire

// ### bus_ctl_model.sv
// Purpose: two-wire bus controller model
// Assumes: a high output pulls its line low
// Notes: bounded wait while the clock is stretched
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
    input wire logic scl_i,
    output logic scl_low_o,
    output logic sda_low_o,
    output logic stall_o
);
    initial {scl_low_o, sda_low_o, stall_o} = 3'h0;
    task automatic clk_bit(input logic b);
        int k = 0;
        sda_low_o = !b;
        #20 scl_low_o = 0;
        while (!scl_i && k < 500) begin
            #4 k++;
        end
        if (k == 500) stall_o = 1;
        #40 scl_low_o = 1;
        #20;
    endtask
    task automatic start();
        sda_low_o = 1;
        #40 scl_low_o = 1;
        #20;
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_bit(b[i]);
        clk_bit(1'b1);
    endtask
    task automatic stop();
        sda_low_o = 1;
        #20 scl_low_o = 0;
        #40 sda_low_o = 0;
        #40;
    endtask
endmodule
`default_nettype wire

// ### test_i2c_slave_hold_collision_ctrl.sv
// Purpose: random and corner runs of the hold block
// Assumes: controller model drives the bus
// Notes: xorshift with a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_hold_collision_ctrl;
    logic clk_i = 0, nrst_i = 0, ah = 0, dh = 0, ce = 0, rel = 0, txd = 0, cclr = 0;
    logic sd = 0, full = 0, oclr = 0, ms, md, soe, doe, crb, bcf, rof, am, bd, so, sdo, stall;
    logic [6:0] own = 7'h00;
    logic [7:0] rxb;
    logic [31:0] seed = 32'h3931_79cb, r;
    int miscompares = 0, cmp_count = 0;
    wire scl = !(ms | soe);
    wire sda = !(md | doe);
    always #2 clk_i = ~clk_i;
    i2c_slave_hold_collision_ctrl dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
        .sda_i(sda), .scl_o(so), .scl_oe_o(soe), .sda_o(sdo), .sda_oe_o(doe),
        .address_hold_enable_i(ah), .data_hold_enable_i(dh),
        .target_collision_detect_enable_i(ce), .own_addr_i(own), .release_set_i(rel),
        .tx_drive_i(txd), .tx_bit_i(1'b1), .collision_flag_clear_i(cclr),
        .spi_byte_done_i(sd), .rx_buffer_full_i(full), .overflow_flag_clear_i(oclr),
        .clock_release_bit_o(crb), .bus_collision_flag_o(bcf), .receive_overflow_flag_o(rof),
        .addr_match_o(am), .rx_byte_o(rxb), .byte_done_o(bd));
    bus_ctl_model ctl_u (.scl_i(scl), .scl_low_o(ms), .sda_low_o(md), .stall_o(stall));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic serve(input int n, input logic a, h, m, input logic [7:0] d);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            while (bd !== 1'b1 && k < 900) begin
                tick();
                k++;
            end
            chk("byte_done", 1, bd);
            if (k == 900) finish_test();
            if (i == 0) chk("match", m, am);
            if (i == 1) chk("rx_byte", d, rxb);
            chk("ack", i ? 1 : m, doe);
            chk("sda_out", i ? 0 : !m, sdo);
            chk("release", !(i ? h : a && m), crb);
            if (crb === 1'b0) begin
                repeat (rnd() % 8 + 1) tick();
                chk("held", 0, crb);
                chk("scl_out", 0, so);
                rel = 1;
                tick();
                rel = 0;
                tick();
                chk("scl_oe", 0, soe);
            end
            tick();
        end
    endtask
    task automatic run(input logic [4:0] v);
        logic [7:0] d;
        d = v[4] ? 8'h00 : 8'(rnd());
        {txd, ce, dh, ah} = {v[4], v[2:0]};
        fork
            begin
                ctl_u.start();
                ctl_u.send({(v[3] ? own : ~own), 1'b0});
                ctl_u.send(d);
                ctl_u.stop();
            end
            serve(v[3] && !v[4] ? 2 : 1, v[0], v[1], v[3], d);
        join
        tick();
        chk("collision", v[2] & v[3] & v[4], bcf);
        chk("idle", 0, soe);
        cclr = 1;
        tick();
        cclr = 0;
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        #1 nrst_i = 1;
        own = 7'(rnd());
        for (int i = 0; i < 6; i++) run(5'(48'h1c18_0b03_0a09 >> (8 * i)));
        repeat (10) run(5'(rnd()));
        repeat (6) begin
            r = rnd();
            full = r[0];
            oclr = r[1];
            sd = 1;
            tick();
            sd = 0;
            chk("overflow", r[0], rof);
            oclr = 1;
            tick();
            oclr = 0;
            tick();
        end
        chk("ctl_stall", 0, stall);
        finish_test();
    end
endmodule
`default_nettype wire
